// ---- bench/page_source.sv ----
// link partner page source
`timescale 1ns/1ps
module page_source (
    // clock
    input wire logic hclk,
    // request from bench
    input wire logic send,
    input wire logic [15:0] word,
    // page towards the device
    output logic partner_valid,
    output logic [15:0] partner_word
);
    logic [15:0] last = 16'h0;
    initial partner_valid = 1'h0;
    initial partner_word = 16'hFFFF;
    // one-cycle page, word released afterwards
    always @(posedge hclk) begin
        partner_valid <= send;
        partner_word <= send ? word : ~last;
        if (send) last <= word;
    end
endmodule : page_source

// ---- bench/phy_regs_assertions.sv ----
// port checks for the phy register bank
`timescale 1ns/1ps
module phy_regs_assertions
    import phy_regs_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic [1:0] hresp,
    // link state and advertisement
    input wire phy_state_s phy_state,
    input wire adv_s adv,
    input wire logic [15:0] adv_word
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////
    wire logic acc = hsel & htrans[1] & hready;
    wire logic rd = acc & ~hwrite;
    wire logic wr_adv = acc & hwrite & (haddr == 32'h10);
    wire logic [5:0] st_exp = {phy_state.preamble_ok, phy_state.neg_done,
        phy_state.remote_fault, ~(phy_state.repeater_mode & phy_state.neg_disable),
        phy_state.link_valid, phy_state.jabber};
    ////////////////////////////////////////
    AST_ADV_FIXED: assert property (
        adv_word[15:14] == 2'h0 && adv_word[4:0] == SELECTOR_8023)
        else $error("advertisement fixed bits wrong");
    AST_ADV_FIELDS: assert property (adv_word[13:5] == {adv.remote_fault, adv.tech})
        else $error("advertisement word and fields differ");
    AST_ADV_WRITE: assert property (wr_adv |=> ##1 adv_word[13:5] == $past(hwdata[13:5]))
        else $error("advertisement write not applied");
    AST_OKAY: assert property (hresp == HRESP_OKAY)
        else $error("response not okay");
    AST_READ_WAIT: assert property (rd |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    AST_WRITE_READY: assert property (acc && hwrite |=> hreadyout)
        else $error("write stalled");
    AST_STATUS: assert property (
        rd && haddr == 32'h4 && $stable(phy_state) |->
        ##2 hrdata == {25'h0, $past(st_exp, 2), EXT_CAP_VALUE})
        else $error("status read wrong");
    AST_ID_HIGH: assert property (
        rd && haddr == 32'h8 |-> ##2 hrdata == {16'h0, PHY_ID_HIGH_VALUE})
        else $error("id high read wrong");
    AST_ID_LOW: assert property (
        rd && haddr == 32'hC |-> ##2 hrdata == {16'h0, PHY_ID_LOW_VALUE})
        else $error("id low read wrong");
    // main scenarios
    COV_PARTNER: cover property (rd && haddr == 32'h14);
    COV_ADV: cover property (wr_adv);
    COV_STATUS: cover property (rd && haddr == 32'h4);
endmodule : phy_regs_assertions

// ---- bench/tb_top.sv ----
// self-checking bench for the phy register bank
`timescale 1ns/1ps
module tb_top
    import phy_regs_pkg::*;
;
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic send = 1'h0, neg_restart = 1'h0, hready, hreadyout, irq, partner_valid;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [1:0] htrans = 2'h0, hresp;
    logic [2:0] hsize = 3'h2;
    logic [15:0] partner_word, word = 16'h0, adv_word;
    phy_state_s phy_state = 7'h0;
    adv_s adv;
    int error_cnt = 0, n_tests = 0, cyc = 0;
    assign hready = hreadyout;
    phy_status_id_autoneg_regs DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .phy_state(phy_state), .partner_valid(partner_valid), .partner_word(partner_word),
        .neg_restart(neg_restart), .adv(adv), .adv_word(adv_word), .irq(irq));
    page_source src (.hclk(hclk), .send(send), .word(word),
        .partner_valid(partner_valid), .partner_word(partner_word));
    initial forever #12.5 hclk = ~hclk;
    ////////////////////////////////////////
    function automatic logic [31:0] exp_adv(input logic [31:0] d);
        return {18'h0, d[13:5], SELECTOR_8023};
    endfunction : exp_adv
    function automatic logic [31:0] exp_status(input phy_state_s s);
        return {25'h0, s.preamble_ok, s.neg_done, s.remote_fault,
            ~(s.repeater_mode & s.neg_disable), s.link_valid, s.jabber, EXT_CAP_VALUE};
    endfunction : exp_status
    task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", s, e, g);
        end
    endtask : check
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test
    // one single transfer, waits for hready at each phase
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hready !== 1'h1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'h1) @(posedge hclk);
        q = hrdata;
    endtask : bus
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input string s);
        bus(a, 1'h0, 32'h0);
        check(s, e, q);
    endtask : rd
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            finish_test();
        end
    end
    ////////////////////////////////////////
    initial begin
        logic [31:0] d;
        logic [15:0] w;
        phy_state_s s;
        void'($urandom(25608));
        repeat (3) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        rd(32'h04, 32'h9, "status");
        rd(32'h08, {16'h0, PHY_ID_HIGH_VALUE}, "id_high");
        rd(32'h0C, {16'h0, PHY_ID_LOW_VALUE}, "id_low");
        d = {18'h0, ADV_REMOTE_FAULT_RESET, ADV_TECH_RESET, 5'h0};
        rd(32'h10, exp_adv(d), "adv");
        rd(32'h3C, 32'h0, "unmapped");
        for (int i = 0; i < 10; i++) begin
            d = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h0 : $urandom;
            bus(32'h10, 1'h1, d);
            rd(32'h10, exp_adv(d), "adv");
            check("adv_word", exp_adv(d), {16'h0, adv_word});
        end
        bus(32'h08, 1'h1, d);
        rd(32'h08, {16'h0, PHY_ID_HIGH_VALUE}, "id_high");
        for (int i = 0; i < 12; i++) begin
            s = (i == 0) ? 7'h0C : (i == 1) ? 7'h08 : 7'($urandom);
            phy_state <= s;
            repeat (2) @(posedge hclk);
            rd(32'h04, exp_status(s), "status");
        end
        w = 16'($urandom);
        word <= w;
        send <= 1'h1;
        @(posedge hclk);
        send <= 1'h0;
        repeat (2) @(posedge hclk);
        rd(32'h14, {16'h0, w | 16'h4000}, "partner");
        bus(32'h14, 1'h1, ~d);
        neg_restart <= 1'h1;
        @(posedge hclk);
        neg_restart <= 1'h0;
        @(posedge hclk);
        rd(32'h14, {16'h0, w & 16'hBFFF}, "partner");
        phy_state <= 7'h0;
        repeat (4) @(posedge hclk);
        bus(32'h20, 1'h0, 32'h0);
        bus(32'h24, 1'h1, 32'h8);
        phy_state <= 7'h1;
        repeat (3) @(posedge hclk);
        check("irq", 32'h1, {31'h0, irq});
        rd(32'h20, 32'h8, "irq_status");
        check("irq", 32'h0, {31'h0, irq});
        bus(32'h24, 1'h1, 32'h0);
        phy_state <= 7'h0;
        repeat (3) @(posedge hclk);
        phy_state <= 7'h1;
        repeat (3) @(posedge hclk);
        check("irq", 32'h0, {31'h0, irq});
        rd(32'h20, 32'h8, "irq_status");
        rd(32'h24, 32'h0, "irq_mask");
        w = 16'($urandom);
        word <= w;
        send <= 1'h1;
        phy_state <= 7'h32;
        @(posedge hclk);
        send <= 1'h0;
        repeat (3) @(posedge hclk);
        rd(32'h20, 32'h17, "irq_status");
        rd(32'h14, {16'h0, w | 16'h4000}, "partner");
        finish_test();
    end
endmodule : tb_top
bind phy_status_id_autoneg_regs phy_regs_assertions chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .phy_state(phy_state), .adv(adv), .adv_word(adv_word));

// ---- logic/ahb_port.sv ----
// ahb-lite slave front end: phases, strobes and wait states
`timescale 1ns/1ps
module ahb_port
    import phy_regs_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave side
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    output logic hreadyout,
    // register side
    output logic wr_strobe,
    output logic rd_strobe,
    output logic [3:0] acc_idx,
    output logic acc_in_range
);

    bus_state_e state;
    bus_state_e next_state;
    wire accept = hsel && htrans[1] && hready;
    wire in_range = (haddr[31:6] == 26'h0);

    // sizes other than a word are served as a word
    wire unused_size = |hsize;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= BUS_IDLE;
            acc_idx <= 4'h0;
            acc_in_range <= 1'b0;
        end else begin
            state <= next_state;
            if (accept) begin
                acc_idx <= haddr[5:2];
                acc_in_range <= in_range;
            end
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            BUS_READ_WAIT: next_state = BUS_READ_DATA;
            default: begin
                if (accept && hwrite) begin
                    next_state = BUS_WRITE;
                end else if (accept) begin
                    next_state = BUS_READ_WAIT;
                end else begin
                    next_state = BUS_IDLE;
                end
            end
        endcase
    end

    assign hreadyout = (state != BUS_READ_WAIT);
    assign wr_strobe = (state == BUS_WRITE);
    assign rd_strobe = (state == BUS_READ_WAIT);

endmodule : ahb_port

// ---- logic/irq_events.sv ----
// sticky event flags, read clear, masked level interrupt
`timescale 1ns/1ps
module irq_events
    import phy_regs_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // events and control
    input wire logic [EV_COUNT-1:0] events,
    input wire logic clear,
    input wire logic [EV_COUNT-1:0] mask,
    // results
    output logic [EV_COUNT-1:0] status,
    output logic irq
);

    // a new event beats the read clear
    wire [EV_COUNT-1:0] next_status = (clear ? '0 : status) | events;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status <= '0;
        end else begin
            status <= next_status;
        end
    end

    assign irq = |(status & mask);

endmodule : irq_events

// ---- logic/phy_regs_pkg.sv ----
// shared constants, types and helpers for the phy management register bank
package phy_regs_pkg;

    // register indices, byte address is four times the index
    localparam logic [3:0] IDX_STATUS = 4'h1;
    localparam logic [3:0] IDX_ID_HIGH = 4'h2;
    localparam logic [3:0] IDX_ID_LOW = 4'h3;
    localparam logic [3:0] IDX_ADV = 4'h4;
    localparam logic [3:0] IDX_PARTNER = 4'h5;
    localparam logic [3:0] IDX_IRQ_STATUS = 4'h8;
    localparam logic [3:0] IDX_IRQ_MASK = 4'h9;

    // status bit positions
    localparam int ST_EXT_CAP = 0;
    localparam int ST_JABBER = 1;
    localparam int ST_LINK = 2;
    localparam int ST_NEG_ABLE = 3;
    localparam int ST_REMOTE_FAULT = 4;
    localparam int ST_NEG_DONE = 5;
    localparam int ST_PREAMBLE_SUPP = 6;
    localparam logic EXT_CAP_VALUE = 1'b1;

    // identification code, values are arbitrary
    localparam logic [15:0] PHY_ID_HIGH_VALUE = 16'h1234;
    localparam logic [15:0] PHY_ID_LOW_VALUE = 16'h5670;

    // advertisement layout and reset values
    localparam int ADV_NEXT_PAGE = 15;
    localparam int ADV_RESERVED = 14;
    localparam int ADV_REMOTE_FAULT = 13;
    localparam int ADV_TECH_LSB = 5;
    localparam int ADV_TECH_MSB = 12;
    localparam logic [4:0] SELECTOR_8023 = 5'h01;
    localparam logic ADV_NEXT_PAGE_VALUE = 1'b0;
    localparam logic ADV_RESERVED_VALUE = 1'b0;
    localparam logic ADV_REMOTE_FAULT_RESET = 1'b0;
    localparam logic [7:0] ADV_TECH_RESET = 8'h0F;

    // partner ability layout
    localparam int PT_ACK = 14;

    // interrupt events
    localparam int EV_LINK = 0;
    localparam int EV_NEG_DONE = 1;
    localparam int EV_REMOTE_FAULT = 2;
    localparam int EV_JABBER = 3;
    localparam int EV_PAGE = 4;
    localparam int EV_COUNT = 5;
    localparam logic [4:0] IRQ_MASK_RESET = 5'h00;

    // bus encodings
    localparam logic [1:0] HRESP_OKAY = 2'h0;

    typedef struct packed {
        logic preamble_ok;
        logic neg_done;
        logic remote_fault;
        logic repeater_mode;
        logic neg_disable;
        logic link_valid;
        logic jabber;
    } phy_state_s;

    typedef struct packed {
        logic remote_fault;
        logic [7:0] tech;
    } adv_s;

    typedef enum logic [3:0] {
        BUS_IDLE = 4'b0001,
        BUS_WRITE = 4'b0010,
        BUS_READ_WAIT = 4'b0100,
        BUS_READ_DATA = 4'b1000
    } bus_state_e;

    function automatic logic rising(input logic prev, input logic cur);
        rising = cur & ~prev;
    endfunction : rising

endpackage : phy_regs_pkg

// ---- logic/phy_status_id_autoneg_regs.sv ----
// phy status, identifier, advertisement and partner ability registers
`timescale 1ns/1ps
module phy_status_id_autoneg_regs
    import phy_regs_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic [1:0] hresp,
    // live link and negotiation state
    input wire phy_state_s phy_state,
    // received partner page
    input wire logic partner_valid,
    input wire logic [15:0] partner_word,
    input wire logic neg_restart,
    // advertised abilities towards the negotiation logic
    output adv_s adv,
    output logic [15:0] adv_word,
    // interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // bus front end

    logic wr_strobe;
    logic rd_strobe;
    logic [3:0] acc_idx;
    logic acc_in_range;

    ahb_port u_ahb_port (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hreadyout(hreadyout),
        .wr_strobe(wr_strobe),
        .rd_strobe(rd_strobe),
        .acc_idx(acc_idx),
        .acc_in_range(acc_in_range)
    );

    assign hresp = HRESP_OKAY;

    ////////////////////////////////////////////////////////////////////////
    // address decode

    wire hit_status = acc_in_range && (acc_idx == IDX_STATUS);
    wire hit_id_high = acc_in_range && (acc_idx == IDX_ID_HIGH);
    wire hit_id_low = acc_in_range && (acc_idx == IDX_ID_LOW);
    wire hit_adv = acc_in_range && (acc_idx == IDX_ADV);
    wire hit_partner = acc_in_range && (acc_idx == IDX_PARTNER);
    wire hit_irq_status = acc_in_range && (acc_idx == IDX_IRQ_STATUS);
    wire hit_irq_mask = acc_in_range && (acc_idx == IDX_IRQ_MASK);

    // only the writable fields have write enables
    wire wr_adv = wr_strobe && hit_adv;
    wire wr_irq_mask = wr_strobe && hit_irq_mask;
    wire rd_irq_status = rd_strobe && hit_irq_status;

    ////////////////////////////////////////////////////////////////////////
    // live state sampling

    phy_state_s sampled;
    phy_state_s sampled_prev;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sampled <= '0;
            sampled_prev <= '0;
        end else begin
            sampled <= phy_state;
            sampled_prev <= sampled;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status register

    wire neg_able = ~(sampled.repeater_mode & sampled.neg_disable);

    logic [15:0] status_word;

    always_comb begin
        status_word = 16'h0000;
        status_word[ST_EXT_CAP] = EXT_CAP_VALUE;
        status_word[ST_JABBER] = sampled.jabber;
        status_word[ST_LINK] = sampled.link_valid;
        status_word[ST_NEG_ABLE] = neg_able;
        status_word[ST_REMOTE_FAULT] = sampled.remote_fault;
        status_word[ST_NEG_DONE] = sampled.neg_done;
        status_word[ST_PREAMBLE_SUPP] = sampled.preamble_ok;
    end

    ////////////////////////////////////////////////////////////////////////
    // advertisement register

    logic adv_remote_fault;
    logic [7:0] adv_tech;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            adv_remote_fault <= ADV_REMOTE_FAULT_RESET;
            adv_tech <= ADV_TECH_RESET;
        end else if (wr_adv) begin
            adv_remote_fault <= hwdata[ADV_REMOTE_FAULT];
            adv_tech <= hwdata[ADV_TECH_MSB:ADV_TECH_LSB];
        end
    end

    always_comb begin
        adv_word = 16'h0000;
        adv_word[ADV_NEXT_PAGE] = ADV_NEXT_PAGE_VALUE;
        adv_word[ADV_RESERVED] = ADV_RESERVED_VALUE;
        adv_word[ADV_REMOTE_FAULT] = adv_remote_fault;
        adv_word[ADV_TECH_MSB:ADV_TECH_LSB] = adv_tech;
        adv_word[4:0] = SELECTOR_8023;
    end

    assign adv.remote_fault = adv_remote_fault;
    assign adv.tech = adv_tech;

    ////////////////////////////////////////////////////////////////////////
    // partner ability register

    logic [15:0] partner_bits;
    logic partner_ack;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            partner_bits <= 16'h0000;
        end else if (partner_valid) begin
            partner_bits <= partner_word;
        end
    end

    // a fresh page in the restart cycle still counts
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            partner_ack <= 1'b0;
        end else if (partner_valid) begin
            partner_ack <= 1'b1;
        end else if (neg_restart) begin
            partner_ack <= 1'b0;
        end
    end

    logic [15:0] partner_view;

    always_comb begin
        partner_view = partner_bits;
        partner_view[PT_ACK] = partner_ack;
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt events

    logic [EV_COUNT-1:0] events;
    logic [EV_COUNT-1:0] irq_status;
    logic [EV_COUNT-1:0] irq_mask;

    always_comb begin
        events = '0;
        events[EV_LINK] = sampled.link_valid ^ sampled_prev.link_valid;
        events[EV_NEG_DONE] = rising(sampled_prev.neg_done, sampled.neg_done);
        events[EV_REMOTE_FAULT] = rising(sampled_prev.remote_fault, sampled.remote_fault);
        events[EV_JABBER] = rising(sampled_prev.jabber, sampled.jabber);
        events[EV_PAGE] = partner_valid;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask <= IRQ_MASK_RESET;
        end else if (wr_irq_mask) begin
            irq_mask <= hwdata[EV_COUNT-1:0];
        end
    end

    irq_events u_irq_events (
        .hclk(hclk),
        .hresetn(hresetn),
        .events(events),
        .clear(rd_irq_status),
        .mask(irq_mask),
        .status(irq_status),
        .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // read path

    logic [31:0] read_value;

    always_comb begin
        read_value = 32'h0000_0000;
        if (hit_status) begin
            read_value[15:0] = status_word;
        end else if (hit_id_high) begin
            read_value[15:0] = PHY_ID_HIGH_VALUE;
        end else if (hit_id_low) begin
            read_value[15:0] = PHY_ID_LOW_VALUE;
        end else if (hit_adv) begin
            read_value[15:0] = adv_word;
        end else if (hit_partner) begin
            read_value[15:0] = partner_view;
        end else if (hit_irq_status) begin
            read_value[EV_COUNT-1:0] = irq_status;
        end else if (hit_irq_mask) begin
            read_value[EV_COUNT-1:0] = irq_mask;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_strobe) begin
            hrdata <= read_value;
        end
    end

endmodule : phy_status_id_autoneg_regs
